/* File: inc/sscf_pkg.sv */
`default_nettype none
package sscf_pkg;

  localparam int NUM_WIN = 32;
  localparam int NUM_LANE = 32;
  localparam int WORD_W = 10;
  localparam int ADDR_W = 8;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_IDENT = 8'h83;
  localparam logic [7:0] ADDR_BLACK = 8'h84;
  localparam logic [7:0] ADDR_IMAGE = 8'h85;
  localparam logic [7:0] ADDR_CHECK = 8'h86;
  localparam logic [7:0] ADDR_TRAIN = 8'h87;

  localparam logic [6:0] RST_IDENT = 7'h2a;
  localparam logic [9:0] RST_BLACK = 10'h015;
  localparam logic [9:0] RST_IMAGE = 10'h035;
  localparam logic [9:0] RST_CHECK = 10'h059;
  localparam logic [9:0] RST_TRAIN = 10'h3a6;

  // ****************************************
  // framing word layout
  // ****************************************
  localparam logic [2:0] TYPE_FRAME_OPEN = 3'h5;
  localparam logic [2:0] TYPE_FRAME_CLOSE = 3'h6;
  localparam logic [2:0] TYPE_ROW_OPEN = 3'h1;
  localparam logic [2:0] TYPE_ROW_CLOSE = 3'h2;
  localparam int TYPE_LSB10 = 7;
  localparam int TYPE_LSB8 = 5;
  localparam int ID8_LSB = 2;

  typedef enum logic [1:0] {
    KIND_TRAIN = 2'h0,
    KIND_BLACK = 2'h1,
    KIND_IMAGE = 2'h2,
    KIND_CHECK = 2'h3
  } sscf_kind_t;

  typedef struct packed {
    logic [6:0] ident;
    logic [9:0] black;
    logic [9:0] image;
    logic [9:0] check;
    logic [9:0] train;
  } sscf_cfg_t;

  localparam sscf_cfg_t CFG_RST = '{RST_IDENT, RST_BLACK, RST_IMAGE, RST_CHECK, RST_TRAIN};

  // readout context for one link word slot
  typedef struct packed {
    sscf_kind_t kind;
    logic [31:0] active;
    logic [31:0] opens;
    logic [31:0] closes;
    logic [31:0] first;
    logic [31:0] last;
  } sscf_seq_t;

  typedef logic [31:0][9:0] sscf_pix_t;

endpackage
`default_nettype wire

/* File: rtl/sscf_framer.sv */
`timescale 1ns/10ps
`default_nettype none
module sscf_framer (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [9:0] reg_wdata_in,
  output logic [9:0] reg_rdata_out,
  input wire logic link_clk_in,
  input wire logic word8_sel_in,
  input wire sscf_pkg::sscf_seq_t seq_in,
  input wire sscf_pkg::sscf_pix_t pix_in,
  output logic link_clk_out,
  output logic [9:0] sync_word_out,
  output sscf_pkg::sscf_pix_t pix_out
);

  // ****************************************
  // register file (register clock)
  // ****************************************
  sscf_pkg::sscf_cfg_t cfg_reg;
  sscf_pkg::sscf_cfg_t snap_reg;
  logic req_tgl_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_tgl_reg;
  logic [9:0] rdata_next;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_reg <= sscf_pkg::CFG_RST;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        sscf_pkg::ADDR_IDENT: cfg_reg.ident <= reg_wdata_in[6:0];
        sscf_pkg::ADDR_BLACK: cfg_reg.black <= reg_wdata_in;
        sscf_pkg::ADDR_IMAGE: cfg_reg.image <= reg_wdata_in;
        sscf_pkg::ADDR_CHECK: cfg_reg.check <= reg_wdata_in;
        sscf_pkg::ADDR_TRAIN: cfg_reg.train <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr_in)
      sscf_pkg::ADDR_IDENT: rdata_next = {3'h0, cfg_reg.ident};
      sscf_pkg::ADDR_BLACK: rdata_next = cfg_reg.black;
      sscf_pkg::ADDR_IMAGE: rdata_next = cfg_reg.image;
      sscf_pkg::ADDR_CHECK: rdata_next = cfg_reg.check;
      sscf_pkg::ADDR_TRAIN: rdata_next = cfg_reg.train;
      default: rdata_next = 10'h000;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 10'h000;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

  // ****************************************
  // configuration crossing, toggle handshake
  // ****************************************
  // snapshot held stable until the link side echoes the toggle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      snap_reg <= sscf_pkg::CFG_RST;
      req_tgl_reg <= 1'b0;
    end else if (req_tgl_reg == ack_s2_reg) begin
      snap_reg <= cfg_reg;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ****************************************
  // link domain reset and pin synchronisers
  // ****************************************
  logic lrst_s1_reg;
  logic lrst_n;
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic w8_s1_reg;
  logic w8_s2_reg;
  sscf_pkg::sscf_cfg_t lcfg_reg;

  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lrst_s1_reg <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_n <= lrst_s1_reg;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      w8_s1_reg <= 1'b0;
      w8_s2_reg <= 1'b0;
    end else begin
      w8_s1_reg <= word8_sel_in;
      w8_s2_reg <= w8_s1_reg;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      lcfg_reg <= sscf_pkg::CFG_RST;
      ack_tgl_reg <= 1'b0;
    end else if (req_s2_reg != req_s3_reg) begin
      lcfg_reg <= snap_reg;
      ack_tgl_reg <= req_s2_reg;
    end
  end

  // host clock is echoed straight through, without the lanes' register delay
  assign link_clk_out = link_clk_in;

  // ****************************************
  // framing event selection
  // ****************************************
  logic [31:0] ev_all;
  logic [31:0] ev_eff;
  logic ev_any;
  logic [4:0] ev_idx;
  logic [4:0] act_idx;
  logic is_black;

  assign ev_all = seq_in.opens | seq_in.closes;
  assign is_black = (seq_in.kind == sscf_pkg::KIND_BLACK);

  // lower window events vanish under an active higher window
  for (genvar i = 0; i < sscf_pkg::NUM_WIN; i++) begin : g_supp
    if (i == sscf_pkg::NUM_WIN - 1) begin : g_top
      assign ev_eff[i] = ev_all[i];
    end else begin : g_low
      assign ev_eff[i] = ev_all[i] & ~(|seq_in.active[31:i+1]);
    end
  end

  assign ev_any = |ev_eff;

  always_comb begin
    ev_idx = 5'h00;
    act_idx = 5'h00;
    for (int k = 0; k < sscf_pkg::NUM_WIN; k++) begin
      if (ev_eff[k]) begin
        ev_idx = 5'(k);
      end
      if (seq_in.active[k] | ev_eff[k]) begin
        act_idx = 5'(k);
      end
    end
  end

  // ****************************************
  // framing word build
  // ****************************************
  logic [2:0] type_next;
  logic [9:0] code_word;
  logic [9:0] class_word;
  logic [9:0] class10;

  always_comb begin
    if (seq_in.opens[ev_idx]) begin
      // black lines never carry frame codes
      if (seq_in.first[ev_idx] && !is_black) begin
        type_next = sscf_pkg::TYPE_FRAME_OPEN;
      end else begin
        type_next = sscf_pkg::TYPE_ROW_OPEN;
      end
    end else begin
      if (seq_in.last[ev_idx] && !is_black) begin
        type_next = sscf_pkg::TYPE_FRAME_CLOSE;
      end else begin
        type_next = sscf_pkg::TYPE_ROW_CLOSE;
      end
    end
  end

  always_comb begin
    if (w8_s2_reg) begin
      code_word = {2'b00, type_next, lcfg_reg.ident[6:2]};
    end else begin
      code_word = {type_next, lcfg_reg.ident};
    end
  end

  always_comb begin
    unique case (seq_in.kind)
      sscf_pkg::KIND_BLACK: class10 = lcfg_reg.black;
      sscf_pkg::KIND_IMAGE: class10 = lcfg_reg.image;
      sscf_pkg::KIND_CHECK: class10 = lcfg_reg.check;
      default: class10 = lcfg_reg.train;
    endcase
  end

  assign class_word = w8_s2_reg ? {2'b00, class10[9:2]} : class10;

  // ****************************************
  // sync slot sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_CLASS = 2'b01,
    ST_WINID = 2'b10
  } sscf_state_t;

  sscf_state_t state_reg;
  sscf_state_t state_next;
  logic [4:0] id_reg;
  logic [9:0] sync_next;
  logic [9:0] id_word;

  // black lines report window 0; receiver ignores it
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      id_reg <= 5'h00;
    end else if (state_reg == ST_CLASS && ev_any) begin
      id_reg <= is_black ? 5'h00 : act_idx;
    end
  end

  assign id_word = w8_s2_reg ? {3'b000, id_reg, 2'b00} : {5'h00, id_reg};

  // an event in the window number slot is not sent
  always_comb begin
    state_next = ST_CLASS;
    sync_next = class_word;
    unique case (state_reg)
      ST_CLASS: begin
        if (ev_any) begin
          state_next = ST_WINID;
          sync_next = code_word;
        end
      end
      ST_WINID: begin
        sync_next = id_word;
      end
      default: begin
        state_next = ST_CLASS;
        sync_next = class_word;
      end
    endcase
  end

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      state_reg <= ST_CLASS;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // output word slot
  // ****************************************
  // sync and lanes register in the same slot
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      sync_word_out <= 10'h000;
    end else begin
      sync_word_out <= sync_next;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      pix_out <= '0;
    end else begin
      for (int n = 0; n < sscf_pkg::NUM_LANE; n++) begin
        if (seq_in.kind == sscf_pkg::KIND_TRAIN) begin
          pix_out[n] <= w8_s2_reg ? {2'b00, lcfg_reg.train[9:2]} : lcfg_reg.train;
        end else if (w8_s2_reg) begin
          pix_out[n] <= {2'b00, pix_in[n][9:2]};
        end else begin
          pix_out[n] <= pix_in[n];
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (!lrst_n);

  property p_train_idle;
    (state_reg == ST_CLASS && !ev_any && seq_in.kind == sscf_pkg::KIND_TRAIN && !w8_s2_reg)
      |=> (sync_word_out == $past(lcfg_reg.train)) && (pix_out[0] == $past(lcfg_reg.train));
  endproperty
  a_train_idle: assert property (p_train_idle) else $error("idle slot lacks pattern");

  property p_winid_follows;
    (state_reg == ST_CLASS && ev_any && !w8_s2_reg)
      |=> ##1 (sync_word_out[9:5] == 5'h00);
  endproperty
  a_winid_follows: assert property (p_winid_follows) else $error("bad window word");

  property p_frame_open;
    (state_reg == ST_CLASS && seq_in.kind == sscf_pkg::KIND_IMAGE && seq_in.opens != 32'h0
     && seq_in.first == seq_in.opens && seq_in.closes == 32'h0
     && (seq_in.active & ~seq_in.opens) == 32'h0 && !w8_s2_reg)
      |=> sync_word_out[9:7] == sscf_pkg::TYPE_FRAME_OPEN;
  endproperty
  a_frame_open: assert property (p_frame_open) else $error("frame open missing");

  property p_black_row;
    (state_reg == ST_CLASS && is_black && seq_in.opens == 32'h1 && seq_in.closes == 32'h0
     && seq_in.active[31:1] == 31'h0 && !w8_s2_reg)
      |=> (sync_word_out[9:7] == sscf_pkg::TYPE_ROW_OPEN) ##1 (sync_word_out == 10'h000);
  endproperty
  a_black_row: assert property (p_black_row) else $error("black line framing wrong");

  property p_overlap;
    (state_reg == ST_CLASS && seq_in.opens == 32'h0 && seq_in.closes == 32'h1
     && (|seq_in.active[31:1]))
      |=> state_reg == ST_CLASS;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlapped code not dropped");

  property p_check_code;
    (state_reg == ST_CLASS && !ev_any && seq_in.kind == sscf_pkg::KIND_CHECK && !w8_s2_reg)
      |=> sync_word_out == $past(lcfg_reg.check);
  endproperty
  a_check_code: assert property (p_check_code) else $error("checksum code missing");

  property p_lane_pass;
    (seq_in.kind == sscf_pkg::KIND_IMAGE && !w8_s2_reg)
      |=> pix_out[31] == $past(pix_in[31]);
  endproperty
  a_lane_pass: assert property (p_lane_pass) else $error("lane data not passed");

  property p_id8_zero;
    (state_reg == ST_WINID && w8_s2_reg)
      |=> (sync_word_out[9:7] == 3'b000) && (sync_word_out[1:0] == 2'b00);
  endproperty
  a_id8_zero: assert property (p_id8_zero) else $error("8-bit window word bits set");

  property p_ident10;
    (state_reg == ST_CLASS && ev_any && !w8_s2_reg)
      |=> sync_word_out[6:0] == $past(lcfg_reg.ident);
  endproperty
  a_ident10: assert property (p_ident10) else $error("framing identifier wrong");

  property p_class8;
    (state_reg == ST_CLASS && !ev_any && seq_in.kind == sscf_pkg::KIND_BLACK && w8_s2_reg)
      |=> sync_word_out == {2'b00, $past(lcfg_reg.black[9:2])};
  endproperty
  a_class8: assert property (p_class8) else $error("8-bit class code wrong");

endmodule // sscf_framer
`default_nettype wire

/* File: sim/sscf_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sscf_rx_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic word8_in,
  input wire logic [6:0] ident_in,
  input wire logic [9:0] train_in,
  input wire logic [9:0] sync_in,
  output logic locked_out,
  output logic [7:0] frames_out
);
  logic [2:0] run_reg;
  logic skip_reg;
  logic [9:0] tr;
  logic [2:0] ty;
  logic fc;
  assign tr = word8_in ? {2'h0, train_in[9:2]} : train_in;
  assign ty = word8_in ? sync_in[7:5] : sync_in[9:7];
  assign fc = word8_in ? (sync_in[4:0] == ident_in[6:2]) : (sync_in[6:0] == ident_in);
  // ****
  // alignment search
  // ****
  // zero lane skew here, so sampling on the echoed edge needs no taps
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg <= 3'h0;
      locked_out <= 1'b0;
    end else if (sync_in != tr) begin
      run_reg <= 3'h0;
    end else if (run_reg == 3'h3) begin
      locked_out <= 1'b1;
    end else begin
      run_reg <= run_reg + 3'h1;
    end
  end
  // ****
  // frame tracking
  // ****
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      skip_reg <= 1'b0;
      frames_out <= 8'h0;
    end else if (skip_reg || !locked_out) begin
      skip_reg <= 1'b0; // window number not used
    end else if (fc) begin
      skip_reg <= 1'b1;
      if (ty == 3'h5) begin
        frames_out <= frames_out + 8'h1;
      end
    end
  end
endmodule // sscf_rx_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h83;
  logic [9:0] wd = 10'h000;
  logic [9:0] rdata;
  logic w8 = 1'b0;
  sscf_pkg::sscf_seq_t seq = '0;
  sscf_pkg::sscf_pix_t pix = '0;
  sscf_pkg::sscf_pix_t pixo;
  sscf_pkg::sscf_pix_t pp = '0;
  sscf_pkg::sscf_cfg_t cf = '{7'h2a, 10'h015, 10'h035, 10'h059, 10'h3a6};
  logic lko;
  logic [9:0] sync;
  logic locked;
  logic [7:0] frames;
  logic [1:0] pk = 2'h0;
  int n_mismatch = 0;
  int checked = 0;
  int ns = 0;
  always #2 clk = ~clk;
  initial begin
    #3;
    forever #24 lclk = ~lclk;
  end
  sscf_framer i_sscf_framer (.clk_in(clk), .nrst_in(nrst), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_rdata_out(rdata), .link_clk_in(lclk), .word8_sel_in(w8),
    .seq_in(seq), .pix_in(pix), .link_clk_out(lko), .sync_word_out(sync), .pix_out(pixo));
  sscf_rx_model i_sscf_rx_model (.clk_in(lko), .nrst_in(nrst), .word8_in(w8),
    .ident_in(cf.ident), .train_in(cf.train), .sync_in(sync), .locked_out(locked),
    .frames_out(frames));
  // ****
  // helpers
  // ****
  task automatic finish_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [319:0] got, input logic [319:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] cw(input logic [9:0] c);
    return w8 ? {2'h0, c[9:2]} : c;
  endfunction
  function automatic logic [9:0] fw(input logic [2:0] t);
    return w8 ? {2'h0, t, cf.ident[6:2]} : {t, cf.ident};
  endfunction
  function automatic logic [9:0] wn(input logic [4:0] n);
    return w8 ? {3'h0, n, 2'h0} : {5'h0, n};
  endfunction
  // checks output of previous slot, then drives the next one
  task automatic slot(input logic [1:0] k, input logic [31:0] a, input logic [31:0] o,
      input logic [31:0] c, input logic [31:0] f, input logic [31:0] l, input logic [9:0] e);
    sscf_pkg::sscf_pix_t ep;
    @(negedge lclk);
    for (int i = 0; i < 32; i++) begin
      ep[i] = cw(pk == 2'h0 ? cf.train : pp[i]);
    end
    chk(320'(sync), 320'(e));
    chk(pixo, ep);
    pk = k;
    for (int i = 0; i < 32; i++) begin
      pix[i] = 10'(i * 37 + ns);
    end
    ns++;
    pp = pix;
    seq = '{sscf_pkg::sscf_kind_t'(k), a, o, c, f, l};
  endtask
  task automatic wrr(input logic [7:0] a, input logic [9:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk(320'(rdata), 320'(e));
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rd(8'h83, 10'h02a);
    rd(8'h84, 10'h015);
    rd(8'h85, 10'h035);
    rd(8'h86, 10'h059);
    rd(8'h87, 10'h3a6);
    rd(8'h88, 10'h000);
  endtask
  task automatic t_train;
    repeat (6) slot(2'h0, '0, '0, '0, '0, '0, cw(cf.train));
  endtask
  task automatic t_frame(input int n);
    logic [31:0] a;
    logic [7:0] f0;
    a = 32'h1 << n;
    f0 = frames;
    slot(2'h2, a, a, '0, a, '0, cw(cf.train));
    slot(2'h2, a, '0, '0, '0, '0, fw(3'h5));
    slot(2'h2, a, '0, '0, '0, '0, wn(n[4:0]));
    slot(2'h2, a, '0, a, '0, '0, cw(cf.image));
    slot(2'h3, a, '0, '0, '0, '0, fw(3'h2));
    slot(2'h3, '0, '0, '0, '0, '0, wn(n[4:0]));
    slot(2'h2, a, a, '0, '0, '0, cw(cf.check));
    slot(2'h2, a, '0, '0, '0, '0, fw(3'h1));
    slot(2'h2, a, '0, a, '0, a, wn(n[4:0]));
    slot(2'h2, a, '0, '0, '0, '0, fw(3'h6));
    slot(2'h0, '0, '0, '0, '0, '0, wn(n[4:0]));
    slot(2'h0, '0, '0, '0, '0, '0, cw(cf.train));
    chk(320'(frames), 320'(f0 + 8'h1));
  endtask
  task automatic t_overlap;
    slot(2'h2, 32'h21, '0, 32'h1, '0, '0, cw(cf.train));
    slot(2'h2, 32'h20, '0, '0, '0, '0, cw(cf.image));
    slot(2'h2, 32'h21, 32'h21, '0, '0, '0, cw(cf.image));
    slot(2'h2, 32'h21, '0, '0, '0, '0, fw(3'h1));
    slot(2'h2, 32'h21, '0, 32'h20, '0, '0, wn(5'd5));
    slot(2'h2, 32'h21, '0, '0, '0, '0, fw(3'h2));
    slot(2'h0, '0, '0, '0, '0, '0, wn(5'd5));
    slot(2'h0, '0, '0, '0, '0, '0, cw(cf.train));
  endtask
  task automatic t_black;
    logic [7:0] f0;
    f0 = frames;
    repeat (2) begin
      slot(2'h1, 32'h1, 32'h1, '0, '0, '0, cw(cf.train));
      slot(2'h1, 32'h1, '0, '0, '0, '0, fw(3'h1));
      slot(2'h1, 32'h1, '0, '0, '0, '0, wn(5'd0));
      slot(2'h1, 32'h1, '0, 32'h1, '0, '0, cw(cf.black));
      slot(2'h0, '0, '0, '0, '0, '0, fw(3'h2));
      slot(2'h0, '0, '0, '0, '0, '0, wn(5'd0));
    end
    slot(2'h0, '0, '0, '0, '0, '0, cw(cf.train));
    chk(320'(frames), 320'(f0));
  endtask
  task automatic t_regwr;
    wrr(8'h87, 10'h2b3);
    wrr(8'h84, 10'h0f3);
    wrr(8'h83, 10'h055);
    wrr(8'h88, 10'h3ff);
    cf.train = 10'h2b3;
    cf.black = 10'h0f3;
    cf.ident = 7'h55;
    rd(8'h87, 10'h2b3);
    rd(8'h84, 10'h0f3);
    rd(8'h83, 10'h055);
    rd(8'h88, 10'h000);
    repeat (12) @(negedge lclk);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge lclk);
    t_regs;
    t_train;
    chk(320'(locked), 320'h1);
    t_frame(31);
    t_overlap;
    t_black;
    w8 = 1'b1;
    repeat (6) @(negedge lclk);
    t_train;
    t_frame(3);
    t_black;
    w8 = 1'b0;
    repeat (6) @(negedge lclk);
    t_regwr;
    t_train;
    t_black;
    finish_test;
  end
  initial begin
    #60000;
    n_mismatch++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
